// ### hdl/kbd_link_ctrl.v
/*
  Keyboard serial link controller: a stream FIFO module and the controller top.
  Assumes the keyboard waits for the acknowledge of each byte before sending the next,
  and that rx_clk/rx_data arrive asynchronously from the keyboard pins.
  Limitations: frames carry no start bit, so a stray line clock edge misaligns every
  later frame until reset; a byte that arrives while the FIFO is full is dropped
  without a flag, though it is still acknowledged.
  The FIFO depth must be a power of two, since its pointers use a wrap bit.
*/
// Contract
// - Receive serial keyboard bytes and check the parity of each one.
// - Translate each scan code and present it in the host output buffer.
// - Raise an interrupt whenever a byte is loaded into the output buffer.
// - Provide polled status showing when a received byte waits.
// - Host writes a byte to the buffer; controller transmits it to keyboard.
// - Acknowledge every byte received over the keyboard link.
// - One buffer-full interrupt serves receive handling only; transmit state is polled in status bits 2 and 3.
`timescale 1ns/10ps
`include "kbd_link_defines.vh"

module kbd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_sys,
  input wire arst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  // Flags and read port are combinational; the controller registers what it shows
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_q[AW-1:0]];

  // Pointers carry an extra wrap bit so full and empty are exact
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // Storage has no reset; only written slots are ever read
  always @(posedge clk_sys) begin
    if (in_valid && !full) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule // kbd_fifo

module kbd_link_ctrl #(
  parameter FIFO_DEPTH = `FIFO_DEPTH,
  parameter BIT_HALF = `BIT_HALF_CYC
) (
  input wire clk_sys,
  input wire arst_n,
  input wire rx_clk,
  input wire rx_data,
  output reg ack_clk,
  output reg ack_data,
  input wire host_rd,
  input wire host_wr,
  input wire [7:0] host_wdata,
  output reg [7:0] host_rdata,
  output reg [3:0] host_status,
  output reg host_irq
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SEND = 3'b010;
  localparam ST_GAP = 3'b100;

  // Scan code translation: set-2 style codes folded to a compact set
  function [7:0] xlate;
    input [7:0] code;
    begin
      case (code)
        8'h76: xlate = 8'h01;
        8'h16: xlate = 8'h02;
        8'h1E: xlate = 8'h03;
        8'h26: xlate = 8'h04;
        8'h25: xlate = 8'h05;
        8'h2E: xlate = 8'h06;
        8'h5A: xlate = 8'h1C;
        8'h29: xlate = 8'h39;
        8'h0D: xlate = 8'h0F;
        8'h66: xlate = 8'h0E;
        default: xlate = code;
      endcase
    end
  endfunction

  // Address width for the FIFO, so a changed depth keeps the pointers exact
  function integer addr_bits;
    input integer depth;
    integer n;
    begin
      n = 0;
      while ((1 << n) < depth) begin
        n = n + 1;
      end
      addr_bits = n;
    end
  endfunction

  // Nine-bit link frame: odd parity on top so the shifter sends data LSB first
  function [8:0] odd_frame;
    input [7:0] data;
    begin
      odd_frame = {~^data, data};
    end
  endfunction

  // Two-flop synchronisers on the keyboard pins
  reg rclk_m_q;
  reg rclk_s_q;
  reg rclk_p_q;
  reg rdat_m_q;
  reg rdat_s_q;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rclk_m_q <= 1'b1;
      rclk_s_q <= 1'b1;
      rclk_p_q <= 1'b1;
      rdat_m_q <= 1'b1;
      rdat_s_q <= 1'b1;
    end else begin
      rclk_m_q <= rx_clk;
      rclk_s_q <= rclk_m_q;
      rclk_p_q <= rclk_s_q;
      rdat_m_q <= rx_data;
      rdat_s_q <= rdat_m_q;
    end
  end
  wire rclk_fall = rclk_p_q && !rclk_s_q;

  // Receive shifter: data LSB first, then odd parity; 9 bits per frame
  reg [8:0] rx_sh_q;
  reg [3:0] rx_cnt_q;
  reg rx_done_q;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_sh_q <= 9'h000;
      rx_cnt_q <= 4'h0;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (rclk_fall) begin
        rx_sh_q <= {rdat_s_q, rx_sh_q[8:1]};
        if (rx_cnt_q == `FRAME_BITS - 1) begin
          rx_cnt_q <= 4'h0;
          rx_done_q <= 1'b1;
        end else begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
        end
      end
    end
  end
  wire rx_par_ok = ^rx_sh_q;
  // A completed frame whose parity fails; shared by the flag and its status bit
  wire rx_bad = rx_done_q && !rx_par_ok;

  // Received bytes queue through the FIFO toward the output buffer
  // Overflow is not reported: the status word has no spare bit for it
  localparam RX_AW = addr_bits(FIFO_DEPTH);
  wire rxf_valid;
  wire [7:0] rxf_data;
  reg obuf_full_q;
  wire obuf_load = rxf_valid && !obuf_full_q;
  kbd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(RX_AW)) u_rx_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(rx_done_q && rx_par_ok),
    .in_ready(),
    .in_data(xlate(rx_sh_q[7:0])),
    .out_valid(rxf_valid),
    .out_ready(!obuf_full_q),
    .out_data(rxf_data)
  );

  // Output buffer, status and interrupt; a load beats a same-cycle read clear
  reg perr_q;
  reg [7:0] tx_byte_q;
  reg tx_pend_q;
  reg ack_pend_q;
  reg [2:0] st_q;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      obuf_full_q <= 1'b0;
      host_rdata <= 8'h00;
      perr_q <= 1'b0;
      host_irq <= 1'b0;
      host_status <= 4'h0;
    end else begin
      if (obuf_load) begin
        obuf_full_q <= 1'b1;
        host_rdata <= rxf_data;
      end else if (host_rd) begin
        obuf_full_q <= 1'b0;
      end
      if (rx_bad) begin
        perr_q <= 1'b1;
      end else if (host_rd) begin
        perr_q <= 1'b0;
      end
      // Interrupt mirrors the receive full flag; transmit state shows only in status
      host_irq <= obuf_load || (obuf_full_q && !(host_rd && !obuf_load));
      host_status[`ST_FULL] <= obuf_load || (obuf_full_q && !host_rd);
      host_status[`ST_PERR] <= rx_bad || (perr_q && !host_rd);
      host_status[`ST_TXBUSY] <= (st_q != ST_IDLE);
      host_status[`ST_TXFULL] <= tx_pend_q;
    end
  end

  // Transmitter: acknowledges take priority over host bytes
  reg [8:0] tx_sh_q;
  reg [3:0] tx_cnt_q;
  reg [15:0] div_q;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      tx_byte_q <= 8'h00;
      tx_pend_q <= 1'b0;
      ack_pend_q <= 1'b0;
      tx_sh_q <= 9'h1FF;
      tx_cnt_q <= 4'h0;
      div_q <= 16'h0000;
      ack_clk <= 1'b1;
      ack_data <= 1'b1;
    end else begin
      // A write while the holding register is full is dropped; software polls bit 3
      if (host_wr && !tx_pend_q) begin
        tx_byte_q <= host_wdata;
        tx_pend_q <= 1'b1;
      end
      if (rx_done_q) begin
        ack_pend_q <= 1'b1;
      end
      // Divider paces both line clock edges; data moves as the clock falls, and is set high again in the gap
      case (st_q)
        ST_IDLE: begin
          div_q <= 16'h0000;
          if (ack_pend_q && !rx_done_q) begin
            ack_pend_q <= 1'b0;
            tx_sh_q <= odd_frame(`ACK_BYTE);
            tx_cnt_q <= 4'h0;
            st_q <= ST_SEND;
          end else if (tx_pend_q && !ack_pend_q) begin
            tx_pend_q <= 1'b0;
            tx_sh_q <= odd_frame(tx_byte_q);
            tx_cnt_q <= 4'h0;
            st_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (div_q == BIT_HALF[15:0] - 16'h0001) begin
            div_q <= 16'h0000;
            ack_clk <= ~ack_clk;
            if (ack_clk) begin
              ack_data <= tx_sh_q[0];
              tx_sh_q <= {1'b1, tx_sh_q[8:1]};
            end else if (tx_cnt_q == `FRAME_BITS - 1) begin
              st_q <= ST_GAP;
            end else begin
              tx_cnt_q <= tx_cnt_q + 4'h1;
            end
          end else begin
            div_q <= div_q + 16'h0001;
          end
        end
        ST_GAP: begin
          ack_data <= 1'b1;
          if (div_q == BIT_HALF[15:0] - 16'h0001) begin
            div_q <= 16'h0000;
            st_q <= ST_IDLE;
          end else begin
            div_q <= div_q + 16'h0001;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // kbd_link_ctrl

// ### hdl/kbd_link_defines.vh
/*
  Timing counts, frame layout and status bit positions for the keyboard link controller.
  Assumes a 100 MHz system clock; included by the controller source only.
*/
`ifndef KBD_LINK_DEFINES_VH
`define KBD_LINK_DEFINES_VH

// Line clock half period for the controller-driven link, in ns and cycles
`define BIT_HALF_NS 20000
`define CLK_PERIOD_NS 10
`define BIT_HALF_CYC (`BIT_HALF_NS / `CLK_PERIOD_NS)
// Frame: 8 data bits, 1 odd parity bit
`define FRAME_BITS 9
// Status bit positions
`define ST_FULL 0
`define ST_PERR 1
`define ST_TXBUSY 2
`define ST_TXFULL 3
// Acknowledge byte returned to the keyboard
`define ACK_BYTE 8'hFA
`define FIFO_DEPTH 16

`endif

// ### verification/kbd_link_assertions.sv
/* Port checker for the keyboard link controller, bound into every kbd_link_ctrl.
   Assumes one clock domain and that BIT_HALF matches the bound instance. */
`timescale 1ns/10ps
module kbd_link_checker #(
  parameter BIT_HALF = 4
) (
  input wire clk_sys,
  input wire arst_n,
  input wire ack_clk,
  input wire ack_data,
  input wire host_rd,
  input wire host_wr,
  input wire [7:0] host_rdata,
  input wire [3:0] host_status,
  input wire host_irq
);
  integer lo_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Counts low cycles of the line clock; a counter keeps long halves cheap
  always @(posedge clk_sys or negedge arst_n)
    if (!arst_n) lo_q <= 0;
    else lo_q <= ack_clk ? 0 : lo_q + 1;
  a_irq_full: assert property (host_irq == host_status[0])
    else $error("irq vs full");
  a_half_low: assert property ($rose(ack_clk) |-> lo_q == BIT_HALF)
    else $error("half period");
  a_rise_data: assert property ($rose(ack_clk) |-> $stable(ack_data))
    else $error("data at rise");
  a_wr_take: assert property (host_wr ##1 !host_status[3] |=> host_status[3])
    else $error("write lost");
  a_rd_full: assert property (host_rd && host_status[0] |=> !host_status[0])
    else $error("full kept");
  a_rd_perr: assert property (host_rd && host_status[1] |=> !host_status[1])
    else $error("perr kept");
  a_full_hold: assert property (host_status[0] && !host_rd |=> host_status[0])
    else $error("full lost");
  a_perr_hold: assert property (host_status[1] && !host_rd |=> host_status[1])
    else $error("perr lost");
  a_data_hold: assert property (host_status[0] && !host_rd |=> $stable(host_rdata))
    else $error("data moved");
  c_full: cover property ($rose(host_status[0]));
  c_perr: cover property ($rose(host_status[1]));
  c_tx: cover property ($rose(host_status[3]));
endmodule // kbd_link_checker
bind kbd_link_ctrl kbd_link_checker #(.BIT_HALF(BIT_HALF)) u_chk (.clk_sys(clk_sys),
  .arst_n(arst_n), .ack_clk(ack_clk), .ack_data(ack_data), .host_rd(host_rd),
  .host_wr(host_wr), .host_rdata(host_rdata), .host_status(host_status), .host_irq(host_irq));

// ### verification/kbd_model.sv
/* Keyboard side of the serial link: sends framed bytes, collects returned frames.
   Assumes the bench clears nb after reset, since reset edges look like clock rises. */
`timescale 1ns/10ps
module kbd_model (
  input wire clk_sys,
  input wire ack_clk,
  input wire ack_data,
  output reg rx_clk,
  output reg rx_data
);
  reg [8:0] sh_q;
  reg [8:0] got;
  integer nb;
  integer n_got;
  // Line clock idles high and stands still between frames
  initial begin
    rx_clk = 1'b1;
    rx_data = 1'b1;
    nb = 0;
    n_got = 0;
  end
  // Returned frames arrive LSB first, parity last; data is steady at the rise
  always @(posedge ack_clk) begin
    sh_q = {ack_data, sh_q[8:1]};
    nb = nb + 1;
    if (nb == 9) begin
      got = sh_q;
      nb = 0;
      n_got = n_got + 1;
    end
  end
  // One frame; bad flips the parity on purpose
  task send(input [7:0] b, input bad);
    reg [8:0] f;
    integer i;
    integer n0;
    begin
      f = {~^b ^ bad, b};
      n0 = n_got;
      for (i = 0; i < 9; i = i + 1) begin
        @(posedge clk_sys) #1 rx_data = f[i];
        repeat (8) @(posedge clk_sys);
        #1 rx_clk = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1 rx_clk = 1'b1;
      end
      rx_data = 1'b1; // Released line returns to its pull-up level
      wait (n_got != n0);
    end
  endtask
endmodule // kbd_model

// ### verification/kbd_link_ctrl_bench.sv
/* Self-checking bench for the keyboard link controller with a keyboard model.
   Assumes a short line clock half period and an output buffer behind the FIFO. */
`timescale 1ns/10ps
module kbd_link_ctrl_bench;
  reg clk_sys = 1'b0;
  reg arst_n = 1'b0;
  reg host_rd = 1'b0;
  reg host_wr = 1'b0;
  reg [7:0] host_wdata = 8'h00;
  reg [7:0] b;
  wire rx_clk, rx_data, ack_clk, ack_data, host_irq;
  wire [7:0] host_rdata;
  wire [3:0] host_status;
  integer n_fail = 0, compares = 0, i, k;
  integer q[$];
  always #5 clk_sys = ~clk_sys;
  kbd_link_ctrl #(.BIT_HALF(4)) DUT (.clk_sys(clk_sys), .arst_n(arst_n), .rx_clk(rx_clk),
    .rx_data(rx_data), .ack_clk(ack_clk), .ack_data(ack_data), .host_rd(host_rd),
    .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_status(host_status), .host_irq(host_irq));
  kbd_model M (.clk_sys(clk_sys), .ack_clk(ack_clk), .ack_data(ack_data),
    .rx_clk(rx_clk), .rx_data(rx_data));
  // Reference translation table, kept apart from the design's copy
  function [7:0] exp_code(input [7:0] c);
    case (c)
      8'h76: exp_code = 8'h01;
      8'h16: exp_code = 8'h02;
      8'h1E: exp_code = 8'h03;
      8'h26: exp_code = 8'h04;
      8'h25: exp_code = 8'h05;
      8'h2E: exp_code = 8'h06;
      8'h5A: exp_code = 8'h1C;
      8'h29: exp_code = 8'h39;
      8'h0D: exp_code = 8'h0F;
      8'h66: exp_code = 8'h0E;
      default: exp_code = c;
    endcase
  endfunction
  task tally(input bad, input [8:0] e, input [8:0] a);
    begin
      compares = compares + 1;
      if (bad) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
      end
    end
  endtask
  // One compare per kind of result: link frame, buffer byte, status flag
  task cmp_frame(input [8:0] e, input [8:0] a);
    tally(a !== e, e, a);
  endtask
  task cmp_data(input [7:0] e, input [7:0] a);
    tally(a !== e, {1'b0, e}, {1'b0, a});
  endtask
  task cmp_flag(input e, input a);
    tally(a !== e, {8'h00, e}, {8'h00, a});
  endtask
  // Read pulse, then settle so the next queued byte can load
  task rd;
    begin
      @(posedge clk_sys) #1 host_rd = 1'b1;
      @(posedge clk_sys) #1 host_rd = 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask
  task conclude;
    begin
      $display("fails=%0d compares=%0d", n_fail, compares);
      if (n_fail == 0 && compares > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Watchdog near 30k cycles, several times the expected 5k
  initial begin
    #300000;
    n_fail = n_fail + 1;
    conclude;
  end
  // Good byte, bad parity, host send, then fill and drain the buffer
  initial begin
    k = $urandom(63);
    repeat (4) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    M.nb = 0;
    b = 8'h5A; // A table code first, so translation is exercised
    M.send(b, 1'b0);
    q.push_back(exp_code(b));
    cmp_frame(9'h1FA, M.got);
    cmp_flag(q.size() != 0, host_status[0]);
    cmp_flag(1'b1, host_irq);
    cmp_data(q[0], host_rdata);
    rd;
    q.delete(0);
    cmp_flag(1'b0, host_irq);
    M.send($urandom, 1'b1);
    cmp_flag(1'b1, host_status[1]);
    cmp_flag(q.size() != 0, host_status[0]);
    cmp_frame(9'h1FA, M.got);
    rd;
    cmp_flag(1'b0, host_status[1]);
    b = $urandom;
    k = M.n_got;
    @(posedge clk_sys) #1 host_wdata = b;
    host_wr = 1'b1;
    @(posedge clk_sys) #1 host_wdata = ~b; // Second write lands on a full holding reg
    @(posedge clk_sys) #1 host_wr = 1'b0;
    cmp_flag(1'b1, host_status[3]);
    wait (M.n_got != k);
    cmp_frame({~^b, b}, M.got);
    repeat (150) @(posedge clk_sys);
    cmp_frame(k + 1, M.n_got);
    cmp_flag(1'b0, host_status[2]);
    // Host stalls; capacity is FIFO depth plus the output buffer
    for (i = 0; i < 20; i = i + 1) begin
      b = $urandom;
      M.send(b, 1'b0);
      cmp_frame(9'h1FA, M.got);
      if (q.size() < 17) q.push_back(exp_code(b));
    end
    for (i = 0; i < 19; i = i + 1) begin
      cmp_flag(q.size() != 0, host_status[0]);
      if (q.size() != 0) begin
        cmp_data(q[0], host_rdata);
        q.delete(0);
      end
      rd;
    end
    conclude;
  end
endmodule // kbd_link_ctrl_bench
